// *** hw/rxev_consts.svh ***
// named offsets, bit positions and counts of the receive event status registers
// assumes inclusion by bare name from the package and the design modules
`ifndef RXEV_CONSTS_SVH
`define RXEV_CONSTS_SVH

`define RXEV_ADDR_INFO1B 8'hC2
`define RXEV_ADDR_INFO2A 8'h31

`define RXEV_B_ALIGN_CHG 7
`define RXEV_B_ZERO8 6
`define RXEV_B_ZERO16 5
`define RXEV_B_SEVERE 2
`define RXEV_B_CODE_WORD 1
`define RXEV_B_FBIT_ERR 0

`define RXEV_B_SYNC 7
`define RXEV_B_LINE_CAR 6
`define RXEV_B_FRM_CAR 5
`define RXEV_B_AIS_END 2

`define RXEV_MASK_INFO1B 8'hE7
`define RXEV_MASK_INFO2A 8'hE4
`define RXEV_REG_RESET 8'h00

`define RXEV_ZERO_SHORT 5'h08
`define RXEV_ZERO_LONG 5'h10
`define RXEV_CW_LEN 8
`define RXEV_CW_MARKS 8'h1B
`define RXEV_SEF_WIN 6
`define RXEV_SEF_LIMIT 3'h2
`define RXEV_ALIGN_W 12

`endif

// *** hw/rxev_pkg.sv ***
// types shared by the receive event status block
// assumes the constants header is on the include path
`include "rxev_consts.svh"

package rxev_pkg;

  // framing events from the receive framer, same clock
  typedef struct packed {
    logic fbit_valid;
    logic fbit_err;
    logic resync_done;
    logic [`RXEV_ALIGN_W-1:0] align_pos;
  } rxev_framer_t;

  // condition levels from framer and line interface, same clock
  typedef struct packed {
    logic sync_ok;
    logic line_carrier_ok;
    logic framer_carrier_ok;
    logic blue_alarm;
  } rxev_levels_t;

  // one-cycle detections from the line monitor
  typedef struct packed {
    logic eight_zero;
    logic sixteen_zero;
    logic code_word;
  } rxev_line_ev_t;

endpackage

// *** hw/rxev_line_mon.sv ***
// zero-run and zero-substitution code word detection on receive bipolar data
// assumes pos/neg already synchronised and bit tick aligned with them
`timescale 1ns/10ps
`include "rxev_consts.svh"

module rxev_line_mon
  import rxev_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_bit_tick,
  input wire logic i_pos,
  input wire logic i_neg,
  output rxev_pkg::rxev_line_ev_t o_ev
);
  import rxev_pkg::*;

  logic [4:0] zero_cnt;
  logic [`RXEV_CW_LEN-1:0] pos_sr;
  logic [`RXEV_CW_LEN-1:0] neg_sr;
  logic last_pol;
  logic last_seen;
  logic mark;
  logic old_mark;
  logic eff_pol;
  logic [`RXEV_CW_LEN-1:0] next_pos;
  logic [`RXEV_CW_LEN-1:0] next_neg;
  logic [`RXEV_CW_LEN-1:0] next_mark;
  logic cw_hit;

  assign mark = i_pos | i_neg;
  assign old_mark = pos_sr[`RXEV_CW_LEN-1] | neg_sr[`RXEV_CW_LEN-1];
  // polarity of last mark before the window, counting the bit leaving now
  assign eff_pol = old_mark ? pos_sr[`RXEV_CW_LEN-1] : last_pol;
  assign next_pos = {pos_sr[`RXEV_CW_LEN-2:0], i_pos};
  assign next_neg = {neg_sr[`RXEV_CW_LEN-2:0], i_neg};
  assign next_mark = next_pos | next_neg;
  // oldest to newest: 0 0 0 V B 0 V B
  assign cw_hit = (last_seen | old_mark) && (next_mark == `RXEV_CW_MARKS)
    && (next_pos[4] == eff_pol) && (next_pos[3] != next_pos[4])
    && (next_pos[1] == next_pos[3]) && (next_pos[0] != next_pos[1]);

  // run length saturates so arbitrarily long runs never wrap
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      zero_cnt <= 5'h00;
    end else if (i_bit_tick) begin
      if (mark) begin
        zero_cnt <= 5'h00;
      end else if (zero_cnt != `RXEV_ZERO_LONG) begin
        zero_cnt <= zero_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pos_sr <= 8'h00;
      neg_sr <= 8'h00;
      last_pol <= 1'b0;
      last_seen <= 1'b0;
    end else if (i_bit_tick) begin
      pos_sr <= next_pos;
      neg_sr <= next_neg;
      last_pol <= eff_pol;
      last_seen <= last_seen | old_mark;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ev <= '0;
    end else begin
      o_ev.eight_zero <= i_bit_tick && !mark && (zero_cnt == `RXEV_ZERO_SHORT - 5'h01);
      o_ev.sixteen_zero <= i_bit_tick && !mark && (zero_cnt == `RXEV_ZERO_LONG - 5'h01);
      o_ev.code_word <= i_bit_tick && cw_hit;
    end
  end

endmodule

// *** hw/rxev_status_regs.sv ***
// receive event status latches read over the parallel control port
// assumes framer inputs share i_ref_clk; line data pins are asynchronous
`timescale 1ns/10ps
`include "rxev_consts.svh"

// What this block does
// R1: first info register of second framer is readable at address C2.
// R2: second info register of first framer is readable at address 31.
// R3: bit 5 sets on a run of sixteen or more zeros on receive data.
// R4: bit 2 sets when two of any six framing bits are errored.
// R5: bit 1 sets on a substitution code word, whatever the decode select.
// R6: bit 7 sets when sync is achieved and holds until read.
// R7: bit 6 sets when line carrier returns and holds until read.
// R8: bit 5 sets when framer carrier returns and holds until read.
// R9: bit 2 sets when the blue alarm ends and holds until read.
// R10: software ignores unassigned bits 4 and 3; here they read zero.
// R11: bit 6 sets on a run of eight or more zeros on receive data.
// R12: bit 0 sets on each errored terminal or pattern framing bit.
// R13: bit 7 sets when resync lands on a different alignment than before.
// R14: reading clears flags, but an event in the read cycle keeps its flag.
module rxev_status_regs
  import rxev_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_rx_positive_data_in,
  input wire logic i_rx_negative_data_in,
  input wire logic i_rx_bit_tick,
  input rxev_pkg::rxev_framer_t i_framer,
  input rxev_pkg::rxev_levels_t i_levels,
  input wire logic [7:0] i_ctl_addr,
  input wire logic i_ctl_rd,
  output logic [7:0] o_ctl_rdata,
  output logic o_ctl_rack
);
  import rxev_pkg::*;

  logic [1:0] pos_sync;
  logic [1:0] neg_sync;
  logic [1:0] tick_dly;
  rxev_line_ev_t line_ev;
  logic [7:0] info1b;
  logic [7:0] info2a;
  logic [7:0] set1b;
  logic [7:0] set2a;
  logic [7:0] clr1b;
  logic [7:0] clr2a;
  logic rd1b;
  logic rd2a;
  rxev_levels_t prev_lv;
  logic [`RXEV_SEF_WIN-1:0] fbit_hist;
  logic [`RXEV_SEF_WIN-1:0] next_hist;
  logic [`RXEV_ALIGN_W-1:0] last_align;
  logic align_known;
  logic align_chg;

  function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
    addr_hit = (addr == target);
  endfunction

  function automatic logic [2:0] ones6(input logic [`RXEV_SEF_WIN-1:0] v);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < `RXEV_SEF_WIN; i++) begin
      n = n + {2'h0, v[i]};
    end
    ones6 = n;
  endfunction

  // pins are asynchronous; tick delayed the same two stages to stay aligned
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      pos_sync <= 2'h0;
      neg_sync <= 2'h0;
      tick_dly <= 2'h0;
    end else begin
      pos_sync <= {pos_sync[0], i_rx_positive_data_in};
      neg_sync <= {neg_sync[0], i_rx_negative_data_in};
      tick_dly <= {tick_dly[0], i_rx_bit_tick};
    end
  end

  // detection ignores the decode select: code words are flagged either way
  rxev_line_mon u_line_mon (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_bit_tick(tick_dly[1]),
    .i_pos(pos_sync[1]),
    .i_neg(neg_sync[1]),
    .o_ev(line_ev)
  );

  assign next_hist = {fbit_hist[`RXEV_SEF_WIN-2:0], i_framer.fbit_err};

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      fbit_hist <= '0;
    end else if (i_framer.fbit_valid) begin
      fbit_hist <= next_hist; // R4
    end
  end

  // first resync after reset has no earlier alignment to differ from
  assign align_chg = i_framer.resync_done && align_known
    && (i_framer.align_pos != last_align);

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      last_align <= '0;
      align_known <= 1'b0;
    end else if (i_framer.resync_done) begin
      last_align <= i_framer.align_pos; // R13
      align_known <= 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prev_lv <= '0;
    end else begin
      prev_lv <= i_levels;
    end
  end

  always_comb begin
    set1b = 8'h00;
    set1b[`RXEV_B_ALIGN_CHG] = align_chg; // R13
    set1b[`RXEV_B_ZERO8] = line_ev.eight_zero; // R11
    set1b[`RXEV_B_ZERO16] = line_ev.sixteen_zero; // R3
    set1b[`RXEV_B_SEVERE] = i_framer.fbit_valid && (ones6(next_hist) >= `RXEV_SEF_LIMIT); // R4
    set1b[`RXEV_B_CODE_WORD] = line_ev.code_word; // R5
    set1b[`RXEV_B_FBIT_ERR] = i_framer.fbit_valid && i_framer.fbit_err; // R12
  end

  always_comb begin
    set2a = 8'h00;
    set2a[`RXEV_B_SYNC] = i_levels.sync_ok && !prev_lv.sync_ok; // R6
    set2a[`RXEV_B_LINE_CAR] = i_levels.line_carrier_ok && !prev_lv.line_carrier_ok; // R7
    set2a[`RXEV_B_FRM_CAR] = i_levels.framer_carrier_ok && !prev_lv.framer_carrier_ok; // R8
    set2a[`RXEV_B_AIS_END] = !i_levels.blue_alarm && prev_lv.blue_alarm; // R9
  end

  assign rd1b = i_ctl_rd && addr_hit(i_ctl_addr, `RXEV_ADDR_INFO1B); // R1
  assign rd2a = i_ctl_rd && addr_hit(i_ctl_addr, `RXEV_ADDR_INFO2A); // R2
  assign clr1b = rd1b ? `RXEV_MASK_INFO1B : 8'h00;
  assign clr2a = rd2a ? `RXEV_MASK_INFO2A : 8'h00;

  // set wins over the read clear so an event during the read is kept
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      info1b <= `RXEV_REG_RESET;
    end else begin
      info1b <= ((info1b & ~clr1b) | set1b) & `RXEV_MASK_INFO1B; // R14
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      info2a <= `RXEV_REG_RESET;
    end else begin
      info2a <= ((info2a & ~clr2a) | set2a) & `RXEV_MASK_INFO2A; // R14
    end
  end

  // unmapped addresses and unassigned bits return zero
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_ctl_rdata <= 8'h00;
      o_ctl_rack <= 1'b0;
    end else begin
      o_ctl_rack <= i_ctl_rd;
      if (rd1b) begin
        o_ctl_rdata <= info1b; // R1
      end else if (rd2a) begin
        o_ctl_rdata <= info2a; // R2
      end else if (i_ctl_rd) begin
        o_ctl_rdata <= 8'h00;
      end
    end
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  sequence s_read_1b;
    i_ctl_rd && (i_ctl_addr == `RXEV_ADDR_INFO1B);
  endsequence

  sequence s_read_2a;
    i_ctl_rd && (i_ctl_addr == `RXEV_ADDR_INFO2A);
  endsequence

  sequence s_sync_up;
    !i_levels.sync_ok ##1 i_levels.sync_ok;
  endsequence

  AST_READ_1B: assert property (s_read_1b |=> o_ctl_rack && o_ctl_rdata == $past(info1b)) // R1
    else $error("info1b read data wrong");
  AST_READ_2A: assert property (s_read_2a |=> o_ctl_rack && o_ctl_rdata == $past(info2a)) // R2
    else $error("info2a read data wrong");
  AST_ZERO16: assert property (line_ev.sixteen_zero |=> info1b[`RXEV_B_ZERO16]) // R3
    else $error("sixteen zero flag not set");
  AST_SEVERE: assert property (i_framer.fbit_valid && i_framer.fbit_err
      && (fbit_hist[4:0] != 5'h00) |=> info1b[`RXEV_B_SEVERE]) // R4
    else $error("severe framing flag not set");
  AST_CODE_WORD: assert property (line_ev.code_word |=> info1b[`RXEV_B_CODE_WORD]) // R5
    else $error("code word flag not set");
  AST_SYNC_SET: assert property (s_sync_up |=> info2a[`RXEV_B_SYNC]) // R6
    else $error("sync regained flag not set");
  AST_SYNC_HOLD: assert property (info2a[`RXEV_B_SYNC] && !rd2a |=> info2a[`RXEV_B_SYNC]) // R6
    else $error("sync regained flag lost without read");
  AST_LINE_CAR: assert property ($rose(i_levels.line_carrier_ok)
      |=> info2a[`RXEV_B_LINE_CAR]) // R7
    else $error("line carrier flag not set");
  AST_FRM_CAR: assert property ($rose(i_levels.framer_carrier_ok)
      |=> info2a[`RXEV_B_FRM_CAR]) // R8
    else $error("framer carrier flag not set");
  AST_AIS_END: assert property ($fell(i_levels.blue_alarm) |=> info2a[`RXEV_B_AIS_END]) // R9
    else $error("blue alarm end flag not set");
  AST_UNASSIGNED: assert property (o_ctl_rack |-> o_ctl_rdata[4:3] == 2'h0) // R10
    else $error("unassigned bits not zero");
  AST_ZERO8: assert property (line_ev.eight_zero |=> info1b[`RXEV_B_ZERO8]) // R11
    else $error("eight zero flag not set");
  AST_FBIT_ERR: assert property (i_framer.fbit_valid && i_framer.fbit_err
      |=> info1b[`RXEV_B_FBIT_ERR]) // R12
    else $error("frame bit error flag not set");
  AST_ALIGN: assert property (align_chg |=> info1b[`RXEV_B_ALIGN_CHG]) // R13
    else $error("alignment change flag not set");
  // checked in the answer cycle: a back-to-back read may replace the data after it
  AST_READ_CLEAR: assert property (s_read_2a ##0 (set2a == 8'h00) |=> info2a == 8'h00
      && o_ctl_rdata == $past(info2a)) // R14
    else $error("read did not clear info2a");
  AST_SET_WINS: assert property (s_read_2a ##0 set2a[`RXEV_B_SYNC]
      |=> info2a[`RXEV_B_SYNC]) // R14
    else $error("event lost during read");

endmodule

// *** testbench/rxev_line_tx.sv ***
// partner model: line side driving the receive rails and the bit tick
// assumes the bench calls send once per line bit, from one process
`timescale 1ns/10ps
module rxev_line_tx (
  input wire logic i_ref_clk,
  output logic o_pos,
  output logic o_neg,
  output logic o_tick
);
  initial begin
    o_pos = 1'b0;
    o_neg = 1'b0;
    o_tick = 1'b0;
  end

  // s: 0 zero, 1 positive mark, 2 negative mark
  task automatic send(input logic [1:0] s);
    @(posedge i_ref_clk);
    #1;
    o_pos = s[0];
    o_neg = s[1];
    o_tick = 1'b1;
    @(posedge i_ref_clk);
    #1;
    o_tick = 1'b0;
    // rails only count at a tick, so scramble them in between
    o_pos = ~s[0];
    o_neg = ~s[1];
  endtask
endmodule

// *** testbench/tb_top.sv ***
// self-checking bench for the receive event status registers
// assumes the line model drives the rails and the bench the framer side
`timescale 1ns/10ps
`include "rxev_consts.svh"
module tb_top;
  import rxev_pkg::*;
  typedef struct packed {
    logic [2:0] k;
    logic [11:0] a;
    logic [7:0] ad;
    logic [7:0] e;
  } rxev_row_t;
  localparam logic [7:0] RB = `RXEV_ADDR_INFO1B;
  localparam logic [7:0] RA = `RXEV_ADDR_INFO2A;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic rack;
  logic pos;
  logic neg;
  logic tick;
  rxev_framer_t fr = '0;
  rxev_levels_t lv = 4'h1;
  int miscompares = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [1:0] cw [9] = '{2'd1, 2'd0, 2'd0, 2'd0, 2'd1, 2'd2, 2'd0, 2'd2, 2'd1};
  // kind: 0 none, 1 framing bits, 2 resync, 3 zero run, 4 code word, 5 levels
  rxev_row_t rows [19] = '{
    '{3'd0, 12'h000, 8'h22, 8'h00}, '{3'd0, 12'h000, RB, 8'h00},
    '{3'd0, 12'h000, RA, 8'h00},
    '{3'd1, 12'h001, RB, 8'h01}, '{3'd1, 12'h041, RB, 8'h01},
    '{3'd1, 12'h021, RB, 8'h05},
    '{3'd2, 12'h123, RB, 8'h00}, '{3'd2, 12'h123, RB, 8'h00},
    '{3'd2, 12'h456, RB, 8'h80},
    '{3'd3, 12'd7, RB, 8'h00}, '{3'd3, 12'd8, RB, 8'h40},
    '{3'd3, 12'd15, RB, 8'h40}, '{3'd3, 12'd16, RB, 8'h60},
    '{3'd4, 12'h000, RB, 8'h02},
    '{3'd5, 12'h009, RA, 8'h80}, '{3'd5, 12'h00D, RA, 8'h40},
    '{3'd5, 12'h00F, RA, 8'h20}, '{3'd5, 12'h00E, RA, 8'h04},
    '{3'd5, 12'h006, RA, 8'h00}};

  rxev_status_regs uut (
    .i_ref_clk(clk), .i_rst(rst), .i_rx_positive_data_in(pos),
    .i_rx_negative_data_in(neg), .i_rx_bit_tick(tick), .i_framer(fr),
    .i_levels(lv), .i_ctl_addr(addr), .i_ctl_rd(rd),
    .o_ctl_rdata(rdata), .o_ctl_rack(rack));
  rxev_line_tx line (.i_ref_clk(clk), .o_pos(pos), .o_neg(neg), .o_tick(tick));

  always #4 clk = ~clk;

  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1;
    addr = a;
    rd = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    chk({7'h00, rack}, 8'h01);
    chk(rdata, e);
  endtask

  task automatic stim(input logic [2:0] k, input logic [11:0] a);
    case (k)
      3'd1: for (int j = 0; j < 8; j++) begin
        @(posedge clk);
        #1;
        fr.fbit_valid = 1'b1;
        fr.fbit_err = a[j];
      end
      3'd2: begin
        @(posedge clk);
        #1;
        fr.resync_done = 1'b1;
        fr.align_pos = a;
      end
      3'd3: begin
        repeat (a) line.send(2'd0);
        line.send(2'd1);
      end
      3'd4: foreach (cw[j]) line.send(cw[j]);
      3'd5: lv = a[3:0];
      default: ;
    endcase
    @(posedge clk);
    #1;
    fr = '0;
  endtask

  initial begin
    repeat (8) @(posedge clk);
    #1;
    chk({7'h00, rack}, 8'h00);
    chk(rdata, 8'h00);
    rst = 1'b0;
    foreach (rows[i]) begin
      stim(rows[i].k, rows[i].a);
      repeat (8) @(posedge clk);
      rd_chk(rows[i].ad, rows[i].e);
    end
    // error arriving in the read cycle must outlive the clear
    @(posedge clk);
    #1;
    addr = RB;
    rd = 1'b1;
    fr.fbit_valid = 1'b1;
    fr.fbit_err = 1'b1;
    @(posedge clk);
    #1;
    rd = 1'b0;
    fr = '0;
    chk(rdata, 8'h00);
    rd_chk(RB, 8'h05);
    rd_chk(RB, 8'h00);
    // sync rising in the read cycle of the second register must outlive the clear
    @(posedge clk);
    #1;
    addr = RA;
    rd = 1'b1;
    lv = 4'hE;
    @(posedge clk);
    #1;
    rd = 1'b0;
    chk(rdata, 8'h00);
    rd_chk(RA, 8'h80);
    stim(3'd1, 12'h001);
    rst = 1'b1;
    @(posedge clk);
    #1;
    rst = 1'b0;
    // sync and carriers still high at release count as risen
    rd_chk(RA, 8'hE0);
    rd_chk(RB, 8'h00);
    report_and_stop();
  end
endmodule
